//--- src/gpbs_pkg.sv
// constants, types and pad carriers for the gpio port with boot strap
// assumes one 25 MHz core clock and an active-low asynchronous chip reset
//
// Functional notes
// (R1) pins 4,5,7-11: input, edge interrupt, output
// (R2) pins 15-12: plain input or output only
// (R3) strap pull-up on while chip reset active
// (R4) strap pull-up off few cycles after release
// (R5) strap level captured at reset release; code samples it 4 cycles later, as the pull-up turns off
// (R6) captured strap shown in general input reg
// (R7) strap low: fetch code from external bus
// (R8) strap high: execute from internal rom
// (R9) pin 6 later general pin or serial receive
// (R10) pins 8,10,11 may become card supply outputs
// (R11) reset pulse held at least one microsecond
// (R12) board ties test-mode inputs high normally
// (R13) interrupt edge sets flag until software clears
package gpbs_pkg;

  ////////////////////////////////////////////////////////////////////////
  // pin map, bit 4 is the lowest pin handled here
  localparam logic [15:4] GPBS_IRQ_CAP = 12'h0fb;
  localparam logic [15:4] GPBS_PLAIN_ONLY = 12'hf00;
  localparam int GPBS_STRAP_PIN = 6;
  localparam int GPBS_CARD0_PIN = 8;
  localparam int GPBS_CARD1_PIN = 10;
  localparam int GPBS_CARD2_PIN = 11;
  localparam int GPBS_PMS_BIT = 0;

  ////////////////////////////////////////////////////////////////////////
  // timing and reset values
  localparam int GPBS_CLK_PERIOD_NS = 40;
  localparam int GPBS_RESET_MIN_NS = 1000;
  localparam int GPBS_RESET_MIN_CYCLES = (GPBS_RESET_MIN_NS + GPBS_CLK_PERIOD_NS - 1) / GPBS_CLK_PERIOD_NS;
  localparam logic [2:0] GPBS_STRAP_HOLD = 3'h4;
  localparam logic [2:0] GPBS_CNT_RST = 3'h0;
  localparam logic [15:4] GPBS_PEND_RST = 12'h000;
  localparam logic GPBS_STRAP_RST = 1'b1;
  // strap pin idles high under its pull-up, so its synchroniser starts there too
  localparam logic [15:4] GPBS_SYNC_RST = 12'h004;

  typedef enum logic [1:0] {
    GPBS_ST_HOLD = 2'b01,
    GPBS_ST_RUN = 2'b10
  } gpbs_state_t;

  typedef struct packed {
    logic [15:4] dir_out;
    logic [15:4] out_val;
    logic [15:4] irq_en;
    logic [15:4] irq_rise;
  } gpbs_cfg_t;

  typedef struct packed {
    logic [15:4] out;
    logic [15:4] oe;
  } gpbs_pad_t;

endpackage

//--- src/gpbs_port.sv
// gpio port pins 4 to 15 with boot strap on pin 6 and card supply on 8, 10, 11
// assumes pad levels arrive asynchronously and configuration comes from core logic
module gpbs_port
  import gpbs_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // pads
  input wire logic [15:4] i_pad_in,
  output gpbs_pad_t o_pad,
  output logic o_strap_pullup_en,
  // configuration from core, test-mode inputs tied on the board
  input wire gpbs_cfg_t i_cfg,
  input wire logic [15:4] i_pend_clr,
  input wire logic [2:0] i_card_supply_en,
  input wire logic i_rxd_sel,
  input wire logic [1:0] i_test_mode_inputs_n,
  // status to core
  output logic [15:0] o_general_input_reg_1,
  output logic [15:4] o_pend,
  output logic o_ext_code_fetch,
  output logic o_int_rom_exec,
  output logic o_rxd,
  output logic [2:0] o_card_supply_out,
  output logic o_test_active
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers; s1 feeds s2 only, s3 is the edge history
  logic [15:4] s1;
  logic [15:4] s2;
  logic [15:4] s3;
  logic [1:0] t1;
  logic [1:0] t2;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= GPBS_SYNC_RST;
      s2 <= GPBS_SYNC_RST;
      s3 <= GPBS_SYNC_RST;
      t1 <= 2'h3;
      t2 <= 2'h3;
    end else begin
      s1 <= i_pad_in;
      s2 <= s1;
      s3 <= s2;
      t1 <= i_test_mode_inputs_n;
      t2 <= t1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap sequencer: pull-up held on through reset and a short tail
  gpbs_state_t state;
  gpbs_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic strap;
  logic next_strap;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_strap = strap;
    case (state)
      GPBS_ST_HOLD: begin
        next_cnt = 3'(cnt + 3'h1);
        // sample late so the synchroniser has settled under the pull-up
        if (cnt == 3'(GPBS_STRAP_HOLD - 3'h1)) begin // [R4]
          next_strap = s2[GPBS_STRAP_PIN]; // [R5]
          next_state = GPBS_ST_RUN;
        end
      end
      GPBS_ST_RUN: begin
        next_state = GPBS_ST_RUN;
      end
      default: begin
        next_state = GPBS_ST_HOLD;
        next_cnt = GPBS_CNT_RST;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= GPBS_ST_HOLD;
      cnt <= GPBS_CNT_RST;
      strap <= GPBS_STRAP_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      strap <= next_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-pin edge detect and pending flags; set beats clear
  logic [15:4] card_mask;
  logic [15:4] ev;
  logic [15:4] next_pend;

  always_comb begin
    card_mask = '0;
    card_mask[GPBS_CARD0_PIN] = i_card_supply_en[0]; // [R10]
    card_mask[GPBS_CARD1_PIN] = i_card_supply_en[1]; // [R10]
    card_mask[GPBS_CARD2_PIN] = i_card_supply_en[2]; // [R10]
  end

  genvar g;
  generate
    for (g = 4; g <= 15; g++) begin : g_pin
      // only capable pins in input mode can raise an event
      // no events in the strap tail: the history still holds its reset value, and a pin high out of reset is no edge
      assign ev[g] = GPBS_IRQ_CAP[g] & i_cfg.irq_en[g] & ~i_cfg.dir_out[g] & ~card_mask[g]
                     & (state == GPBS_ST_RUN)
                     & (i_cfg.irq_rise[g] ? (s2[g] & ~s3[g]) : (~s2[g] & s3[g])); // [R1] [R2]
      assign next_pend[g] = ev[g] | (o_pend[g] & ~i_pend_clr[g]); // [R13]
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pend <= GPBS_PEND_RST;
    end else begin
      o_pend <= next_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pad drive and status
  gpbs_pad_t next_pad;
  logic [15:0] next_gin;
  logic next_pullup;
  logic next_ext;
  logic next_rom;
  logic next_rxd;

  always_comb begin
    next_pad.out = i_cfg.out_val | card_mask; // [R10]
    next_pad.oe = i_cfg.dir_out | card_mask; // [R1] [R2] [R10]
    // strap pin stays undriven until the strap is taken; receive mode is input only
    next_pad.oe[GPBS_STRAP_PIN] = (next_state == GPBS_ST_RUN) & i_cfg.dir_out[GPBS_STRAP_PIN]
                                  & ~i_rxd_sel; // [R9]
    next_pad.out[GPBS_STRAP_PIN] = i_cfg.out_val[GPBS_STRAP_PIN];
    next_gin = {s2, 4'h0};
    next_gin[GPBS_PMS_BIT] = next_strap; // [R6]
    next_pullup = (next_state == GPBS_ST_HOLD); // [R3] [R4]
    next_ext = (next_state == GPBS_ST_RUN) & ~next_strap; // [R7]
    next_rom = (next_state == GPBS_ST_RUN) & next_strap; // [R8]
    // idle-high receive line when the pin is not in serial mode
    next_rxd = i_rxd_sel ? s2[GPBS_STRAP_PIN] : 1'b1; // [R9]
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad <= '0;
      o_general_input_reg_1 <= '0;
      o_strap_pullup_en <= 1'b1; // [R3]
      o_ext_code_fetch <= 1'b0;
      o_int_rom_exec <= 1'b0;
      o_rxd <= 1'b1;
      o_card_supply_out <= 3'h0;
      o_test_active <= 1'b0;
    end else begin
      o_pad <= next_pad;
      o_general_input_reg_1 <= next_gin;
      o_strap_pullup_en <= next_pullup;
      o_ext_code_fetch <= next_ext;
      o_int_rom_exec <= next_rom;
      o_rxd <= next_rxd;
      o_card_supply_out <= i_card_supply_en; // [R10]
      o_test_active <= ~&t2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_no_irq_uncapable;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (o_pend & ~GPBS_IRQ_CAP) == 12'h000;
  endproperty
  a_no_irq_uncapable: assert property (p_no_irq_uncapable) // [R2]
    else $error("pending flag on a pin without interrupt");

  property p_pullup_tail;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      // counted from the release edge, which still samples the reset value
      o_strap_pullup_en |-> ##[1:5] !o_strap_pullup_en;
  endproperty
  a_pullup_tail: assert property (p_pullup_tail) // [R4]
    else $error("strap pull-up not released after reset");

  property p_pullup_stays_off;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !o_strap_pullup_en |=> !o_strap_pullup_en;
  endproperty
  a_pullup_stays_off: assert property (p_pullup_stays_off) // [R3]
    else $error("strap pull-up returned outside reset");

  property p_strap_capture;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $fell(o_strap_pullup_en) |-> o_general_input_reg_1[GPBS_PMS_BIT] == $past(s2[GPBS_STRAP_PIN]);
  endproperty
  a_strap_capture: assert property (p_strap_capture) // [R5]
    else $error("strap level not captured at release");

  property p_strap_kept;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !o_strap_pullup_en |=> $stable(o_general_input_reg_1[GPBS_PMS_BIT]);
  endproperty
  a_strap_kept: assert property (p_strap_kept) // [R6]
    else $error("program memory select bit changed after capture");

  property p_ext_fetch;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !o_strap_pullup_en |-> o_ext_code_fetch == !o_general_input_reg_1[GPBS_PMS_BIT];
  endproperty
  a_ext_fetch: assert property (p_ext_fetch) // [R7]
    else $error("external fetch does not follow low strap");

  property p_int_rom;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !o_strap_pullup_en |-> o_int_rom_exec == o_general_input_reg_1[GPBS_PMS_BIT];
  endproperty
  a_int_rom: assert property (p_int_rom) // [R8]
    else $error("internal rom select does not follow high strap");

  property p_rxd_follow;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_rxd_sel |=> o_rxd == $past(s2[GPBS_STRAP_PIN]) && !o_pad.oe[GPBS_STRAP_PIN];
  endproperty
  a_rxd_follow: assert property (p_rxd_follow) // [R9]
    else $error("serial receive not taken from strap pin");

  property p_card_supply;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_card_supply_en[2] |=> o_pad.oe[GPBS_CARD2_PIN] && o_pad.out[GPBS_CARD2_PIN] && o_card_supply_out[2];
  endproperty
  a_card_supply: assert property (p_card_supply) // [R10]
    else $error("card supply pin not driven");

  property p_pend_set;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      ##1 ($past(ev) & ~o_pend) == 12'h000;
  endproperty
  a_pend_set: assert property (p_pend_set) // [R13]
    else $error("edge event lost");

  property p_pend_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      ##1 ($past(o_pend & ~i_pend_clr) & ~o_pend) == 12'h000;
  endproperty
  a_pend_hold: assert property (p_pend_hold) // [R13]
    else $error("pending flag dropped without clear");

  property p_pend_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      ##1 ($past(i_pend_clr & ~ev) & o_pend) == 12'h000;
  endproperty
  a_pend_clear: assert property (p_pend_clear) // [R13]
    else $error("pending flag not cleared");

  property p_strap_pin_quiet;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_strap_pullup_en |-> !o_pad.oe[GPBS_STRAP_PIN];
  endproperty
  a_strap_pin_quiet: assert property (p_strap_pin_quiet) // [R9]
    else $error("strap pin driven before capture");

  property p_card_supply0;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_card_supply_en[0] |=> o_pad.oe[GPBS_CARD0_PIN] && o_pad.out[GPBS_CARD0_PIN] && o_card_supply_out[0];
  endproperty
  a_card_supply0: assert property (p_card_supply0) // [R10]
    else $error("first card supply pin not driven");

  property p_card_supply1;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_card_supply_en[1] |=> o_pad.oe[GPBS_CARD1_PIN] && o_pad.out[GPBS_CARD1_PIN] && o_card_supply_out[1];
  endproperty
  a_card_supply1: assert property (p_card_supply1) // [R10]
    else $error("second card supply pin not driven");

  property p_rxd_idle;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_rxd_sel |=> o_rxd;
  endproperty
  a_rxd_idle: assert property (p_rxd_idle) // [R9]
    else $error("serial receive line not idle high");

  property p_gin_levels;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !o_strap_pullup_en |=> o_general_input_reg_1[15:4] == $past(s2) && o_general_input_reg_1[3:1] == 3'h0;
  endproperty
  a_gin_levels: assert property (p_gin_levels) // [R1] [R2]
    else $error("general input register does not show pin levels");

  property p_boot_exclusive;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !(o_ext_code_fetch && o_int_rom_exec);
  endproperty
  a_boot_exclusive: assert property (p_boot_exclusive) // [R7] [R8]
    else $error("external fetch and internal rom both selected");

endmodule // gpbs_port

//--- tb/gpbs_board.sv
// board model around the port pads: switches and strap resistor
// assumes device drive wins over board switches wherever its oe is high
module gpbs_board
  import gpbs_pkg::*;
(
  // device side
  input wire gpbs_pad_t i_pad,
  input wire logic i_strap_pullup_en,
  // board side
  input wire logic [15:4] i_sw,
  input wire logic i_float6,
  output logic [15:4] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  // an open strap pin reads high under the pull-up and the inverse once it lets go,
  // so a capture taken too late shows up as the wrong program source
  always_comb begin
    o_level = (i_pad.oe & i_pad.out) | (~i_pad.oe & i_sw);
    if (i_float6 && !i_pad.oe[6]) begin
      o_level[6] = i_strap_pullup_en;
    end
  end
endmodule // gpbs_board

//--- tb/gpbs_port_with_boot_strap_tb.sv
// self-checking bench for the gpio port with boot strap
// assumes the board model closes the pads and a 25 MHz clock
module gpbs_port_with_boot_strap_tb;
  import gpbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:4] sw = 12'h000;
  logic float6 = 1'b0;
  gpbs_cfg_t cfg = '0;
  logic [15:4] pclr = 12'h000;
  logic [2:0] card = 3'h0;
  logic rsel = 1'b0;
  logic [1:0] tst = 2'h3;
  gpbs_pad_t pad;
  logic pu, ext, rom, rxd, tact, strap, r, e, s;
  logic [15:0] gin;
  logic [15:4] pend, lvl, d, v, w, oex, outx;
  logic [2:0] cout, c;
  int bad_count = 0;
  int tests_run = 0;
  int pins[3] = '{GPBS_CARD0_PIN, GPBS_CARD1_PIN, GPBS_CARD2_PIN};
  always #(GPBS_CLK_PERIOD_NS / 2) clk = ~clk;
  gpbs_port gpbs_port_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_pad_in(lvl), .o_pad(pad),
    .o_strap_pullup_en(pu), .i_cfg(cfg), .i_pend_clr(pclr), .i_card_supply_en(card),
    .i_rxd_sel(rsel), .i_test_mode_inputs_n(tst), .o_general_input_reg_1(gin), .o_pend(pend),
    .o_ext_code_fetch(ext), .o_int_rom_exec(rom), .o_rxd(rxd), .o_card_supply_out(cout),
    .o_test_active(tact));
  gpbs_board gpbs_board_i (.i_pad(pad), .i_strap_pullup_en(pu), .i_sw(sw), .i_float6(float6),
    .o_level(lvl));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] g, input logic [23:0] x);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("counts: run=%0d bad=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // strap low means the board carries external program memory
  task automatic do_reset(input logic hi);
    @(posedge clk);
    rst_n <= 1'b0;
    float6 <= hi;
    sw[6] <= 1'b0;
    cyc(GPBS_RESET_MIN_CYCLES);
    chk({ext, rom, pu}, 3'h1);
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    chk(pu, 1'b1);
    cyc(1);
    chk({gin[0], ext, rom, pu}, {hi, !hi, hi, 1'b0});
    // a pin already high out of reset must not look like an edge
    chk(pend, 12'h000);
    strap = hi;
    @(posedge clk);
    float6 <= 1'b0;
    $display("done: reset strap %0d", hi);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(13832));
    do_reset(1'b0);
    for (int p = 4; p < 16; p++) begin
      @(posedge clk);
      r = 1'($urandom_range(1));
      e = 1'($urandom_range(1));
      cfg.irq_rise[p] <= r;
      cfg.irq_en[p] <= e;
      sw[p] <= !r;
      pclr <= 12'hfff;
      cyc(4);
      @(posedge clk);
      pclr <= 12'h000;
      sw[p] <= r;
      cyc(3);
      chk(pend, 12'(GPBS_IRQ_CAP[p] & e) << (p - 4));
      cyc(4);
      chk(pend, 12'(GPBS_IRQ_CAP[p] & e) << (p - 4));
      @(posedge clk);
      pclr[p] <= 1'b1;
      @(posedge clk);
      pclr <= 12'h000;
      #1;
      chk(pend, 12'h000);
    end
    $display("done: edge events");
    cfg.irq_en <= 12'h000;
    repeat (8) begin
      @(posedge clk);
      d = 12'($urandom);
      v = 12'($urandom);
      c = 3'($urandom);
      s = 1'($urandom);
      w = 12'($urandom);
      cfg.dir_out <= d;
      cfg.out_val <= v;
      card <= c;
      rsel <= s;
      oex = d;
      outx = v;
      oex[6] = d[6] & !s;
      for (int k = 0; k < 3; k++) begin
        if (c[k]) begin
          oex[pins[k]] = 1'b1;
          outx[pins[k]] = 1'b1;
        end
      end
      cyc(1);
      chk({pad.out & oex, pad.oe}, {outx & oex, oex});
      chk(cout, c);
      @(posedge clk);
      cfg.dir_out <= 12'h000;
      card <= 3'h0;
      cyc(2);
      @(posedge clk);
      sw <= w;
      cyc(3);
      chk(gin, {w, 3'h0, strap});
      chk(rxd, s ? w[6] : 1'b1);
    end
    $display("done: outputs and inputs");
    @(posedge clk);
    tst <= 2'h2;
    cyc(3);
    chk(tact, 1'b1);
    @(posedge clk);
    tst <= 2'h3;
    cyc(3);
    chk(tact, 1'b0);
    $display("done: test inputs");
    @(posedge clk);
    cfg.irq_en <= 12'hfff;
    cfg.irq_rise <= 12'hfff;
    sw <= 12'h000;
    cyc(4);
    @(posedge clk);
    card <= 3'h7;
    cyc(5);
    chk(pend, 12'h000);
    $display("done: refused events");
    @(posedge clk);
    card <= 3'h0;
    sw <= 12'h0ff;
    do_reset(1'b1);
    report_and_stop();
  end
endmodule // gpbs_port_with_boot_strap_tb
